/* hw/diag_serial_pkg.sv */
package diag_serial_pkg;

    localparam int CHANNELS = 5;
    localparam int CNT_W    = 3;

    localparam logic [2:0] SEL_RESET    = 3'h7;
    localparam logic [2:0] SEL_STANDBY  = 3'h7;
    localparam logic [2:0] SEL_LAST_CH  = 3'h4;
    localparam logic [2:0] CONTROL_ADDR = 3'h7;
    localparam logic [2:0] CNT_FIRST    = 3'h1;
    localparam logic [2:0] CNT_WHOLE    = 3'h0;
    localparam logic       ERR_RESET    = 1'h0;

    typedef struct packed {
        logic       write;
        logic       register_bank_bit;
        logic       addr_bit;
        logic       data_reg_bit;
        logic [3:0] data;
    } frame_s;

    typedef struct packed {
        logic                read_mark;
        logic [2:0]          addr;
        logic                bypass_monitor_bit;
        logic [2:0]          sense_select;
    } control_reply_s;

    typedef struct packed {
        logic                zero;
        logic                limp_home_indicator;
        logic                spare;
        logic [CHANNELS-1:0] channel_fault_flag;
    } std_reply_s;

    typedef struct packed {
        logic [CHANNELS-1:0] channel_on_bit;
        logic [CHANNELS-1:0] channel_fault_flag;
        logic [CHANNELS-1:0] vds_above_thr;
        logic                limp_home_indicator;
    } pins_s;

    typedef enum logic {
        REPLY_STD,
        REPLY_CONTROL
    } reply_kind_e;

endpackage

/* hw/diag_serial_slave_port.sv */
`timescale 1ns/1ps
`default_nettype none
module diag_serial_slave_port (
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    input  wire logic                                 clk_en,
    input  wire logic                                 sclk,
    input  wire logic                                 cs_n,
    input  wire logic                                 si,
    output logic                                      so_o,
    output logic                                      so_oe,
    input  wire logic [diag_serial_pkg::CHANNELS-1:0] channel_on_bit,
    input  wire logic [diag_serial_pkg::CHANNELS-1:0] channel_fault_flag,
    input  wire logic [diag_serial_pkg::CHANNELS-1:0] vds_above_thr,
    input  wire logic                                 limp_home_indicator,
    output logic [diag_serial_pkg::CHANNELS-1:0]      sense_route,
    output logic                                      sense_drive_en,
    output logic                                      standby,
    output logic [2:0]                                sense_select,
    output logic                                      bypass_monitor_bit,
    output logic                                      frame_error_flag
);

    // ---------------- system domain state ----------------
    logic                                 cs_meta_q;
    logic                                 cs_mid_q;
    logic                                 cs_late_q;
    logic                                 cs_stable_q;
    diag_serial_pkg::pins_s               pin_meta_q;
    diag_serial_pkg::pins_s               pin_mid_q;
    diag_serial_pkg::pins_s               pin_late_q;
    diag_serial_pkg::pins_s               pin_q;
    diag_serial_pkg::pins_s               pin_raw;
    diag_serial_pkg::pins_s               pin_d;
    logic [2:0]                           sense_select_q;
    logic                                 frame_error_q;
    diag_serial_pkg::reply_kind_e         reply_kind_q;
    logic [7:0]                           snap_q;
    logic                                 tog_ref_q;
    logic [diag_serial_pkg::CHANNELS-1:0] route_q;
    logic                                 drive_en_q;
    logic                                 standby_q;
    logic                                 bypass_q;

    // ---------------- link domain state ----------------
    logic                                 risen_q;
    logic                                 fresh_q;
    logic                                 so_q;
    logic [7:0]                           shift_q;
    logic [diag_serial_pkg::CNT_W-1:0]    cnt_q;
    logic                                 seen_tog_q;
    logic                                 frame_idle;

    logic                                 cs_agree;
    logic                                 cs_fall;
    logic                                 cs_rise;
    logic                                 frame_ok;
    logic                                 sel_is_channel;
    logic                                 bypass_d;
    diag_serial_pkg::frame_s              rx;
    diag_serial_pkg::std_reply_s          std_word;
    diag_serial_pkg::control_reply_s      ctl_word;

    assign pin_raw = '{channel_on_bit:      channel_on_bit,
                       channel_fault_flag:  channel_fault_flag,
                       vds_above_thr:       vds_above_thr,
                       limp_home_indicator: limp_home_indicator};

    // a pin change counts once the second and third stages agree
    assign pin_d = (pin_mid_q & pin_late_q) | (pin_q & (pin_mid_q ^ pin_late_q));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_q <= '0;
            pin_mid_q  <= '0;
            pin_late_q <= '0;
            pin_q      <= '0;
        end else if (clk_en) begin
            pin_meta_q <= pin_raw;
            pin_mid_q  <= pin_meta_q;
            pin_late_q <= pin_mid_q;
            pin_q      <= pin_d;
        end
    end

    // chip select seen in the system domain; idle level is high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_meta_q   <= 1'h1;
            cs_mid_q    <= 1'h1;
            cs_late_q   <= 1'h1;
            cs_stable_q <= 1'h1;
        end else if (clk_en) begin
            cs_meta_q <= cs_n;
            cs_mid_q  <= cs_meta_q;
            cs_late_q <= cs_mid_q;
            if (cs_agree) begin
                cs_stable_q <= cs_mid_q;
            end
        end
    end

    assign cs_agree = (cs_mid_q == cs_late_q);
    assign cs_fall  = clk_en && cs_agree && cs_stable_q && !cs_mid_q;
    assign cs_rise  = clk_en && cs_agree && !cs_stable_q && cs_mid_q;

    // link registers are quiet here: chip select has been high for the lag time
    assign rx       = diag_serial_pkg::frame_s'(shift_q);
    assign frame_ok = (seen_tog_q != tog_ref_q) && (cnt_q == diag_serial_pkg::CNT_WHOLE);

    assign sel_is_channel = (sense_select_q <= diag_serial_pkg::SEL_LAST_CH);

    always_comb begin
        bypass_d = 1'h0;
        if (sel_is_channel) begin
            bypass_d = pin_q.vds_above_thr[sense_select_q];
        end
    end

    assign std_word = '{zero:                1'h0,
                        limp_home_indicator: pin_q.limp_home_indicator,
                        spare:               1'h0,
                        channel_fault_flag:  pin_q.channel_fault_flag};

    assign ctl_word = '{read_mark:          1'h0,
                        addr:               diag_serial_pkg::CONTROL_ADDR,
                        bypass_monitor_bit: bypass_q,
                        sense_select:       sense_select_q};

    // reply frozen at chip select fall, read by the link side while low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            snap_q <= 8'h00;
        end else if (cs_fall) begin
            if (reply_kind_q == diag_serial_pkg::REPLY_CONTROL) begin
                snap_q <= ctl_word;
            end else begin
                snap_q <= std_word;
            end
        end
    end

    // frame end: decode only whole, nonzero byte counts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sense_select_q <= diag_serial_pkg::SEL_RESET;
            reply_kind_q   <= diag_serial_pkg::REPLY_STD;
            frame_error_q  <= diag_serial_pkg::ERR_RESET;
            tog_ref_q      <= 1'h0;
        end else if (cs_rise) begin
            tog_ref_q <= seen_tog_q;
            if (frame_ok) begin
                frame_error_q <= 1'h0;
                reply_kind_q  <= diag_serial_pkg::REPLY_STD;
                if ({rx.register_bank_bit, rx.addr_bit, rx.data_reg_bit}
                        == diag_serial_pkg::CONTROL_ADDR) begin
                    if (rx.write) begin
                        sense_select_q <= rx.data[2:0];
                    end else begin
                        reply_kind_q <= diag_serial_pkg::REPLY_CONTROL;
                    end
                end
            end else begin
                frame_error_q <= 1'h1;
            end
        end
    end

    // analog switch controls for the sense pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            route_q    <= '0;
            drive_en_q <= 1'h0;
            standby_q  <= 1'h1;
            bypass_q   <= 1'h0;
        end else if (clk_en) begin
            for (int k = 0; k < diag_serial_pkg::CHANNELS; k++) begin
                route_q[k] <= sel_is_channel && (sense_select_q == 3'(k))
                              && pin_q.channel_on_bit[k];
            end
            drive_en_q <= sel_is_channel && pin_q.channel_on_bit[sense_select_q];
            standby_q  <= (sense_select_q == diag_serial_pkg::SEL_STANDBY);
            bypass_q   <= bypass_d;
        end
    end

    // ---------------- link domain, clocked by sclk ----------------
    // chip select high (or reset) ends the frame without needing an sclk edge
    assign frame_idle = cs_n | ~reset_n;

    always_ff @(posedge sclk or posedge frame_idle) begin
        if (frame_idle) begin
            risen_q <= 1'h0;
        end else begin
            risen_q <= 1'h1;
        end
    end

    always_ff @(negedge sclk or posedge frame_idle) begin
        if (frame_idle) begin
            fresh_q <= 1'h1;
        end else begin
            fresh_q <= 1'h0;
        end
    end

    // first rising edge shows the reply msb, later ones the shifted bit
    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            so_q <= 1'h0;
        end else if (!cs_n) begin
            so_q <= risen_q ? shift_q[7] : snap_q[7];
        end
    end

    // count and data survive chip select rise so the system side can read them
    always_ff @(negedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q    <= 8'h00;
            cnt_q      <= '0;
            seen_tog_q <= 1'h0;
        end else if (!cs_n) begin
            if (fresh_q) begin
                shift_q    <= {snap_q[6:0], si};
                cnt_q      <= diag_serial_pkg::CNT_FIRST;
                seen_tog_q <= ~seen_tog_q;
            end else begin
                shift_q <= {shift_q[6:0], si};
                cnt_q   <= cnt_q + 3'h1;
            end
        end
    end

    // the pre-clock bit must follow si live, so this mux cannot be a flop
    assign so_o  = risen_q ? so_q : (frame_error_q | si);
    assign so_oe = ~cs_n;

    assign sense_route        = route_q;
    assign sense_drive_en     = drive_en_q;
    assign standby            = standby_q;
    assign sense_select       = sense_select_q;
    assign bypass_monitor_bit = bypass_q;
    assign frame_error_flag   = frame_error_q;

endmodule
`default_nettype wire

/* tb/diag_serial_master.sv */
`timescale 1ns/1ps
`default_nettype none
module diag_serial_master (
    output logic      cs_n,
    output logic      sclk,
    output logic      si,
    input  wire logic so_o
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end

    // si is driven low before chip select rises, so it reads low until the first bit of the next frame
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx,
                        output logic pre);
        rx = 16'h0;
        cs_n = 1'b0;
        #1000 pre = so_o;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            si = tx[i];
            #40 sclk = 1'b0;
            rx = {rx[14:0], so_o};
            #40;
        end
        #1000 si = 1'b0;
        cs_n = 1'b1;
        #1000;
    endtask
endmodule
`default_nettype wire

/* tb/diag_serial_slave_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module diag_serial_slave_port_checker (
    input wire logic                                 clk,
    input wire logic                                 reset_n,
    input wire logic                                 cs_n,
    input wire logic                                 so_oe,
    input wire logic [diag_serial_pkg::CHANNELS-1:0] sense_route,
    input wire logic                                 sense_drive_en,
    input wire logic                                 standby,
    input wire logic [2:0]                           sense_select,
    input wire logic                                 bypass_monitor_bit,
    input wire logic                                 frame_error_flag
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_oe;
        so_oe == !cs_n;
    endproperty
    a_oe: assert property (p_oe) else $error("so_oe not inverse of cs_n");
    property p_route;
        sense_route != '0 |-> sense_route == (5'h1 << $past(sense_select));
    endproperty
    a_route: assert property (p_route) else $error("wrong channel routed");
    property p_drive;
        sense_drive_en == (sense_route != '0);
    endproperty
    a_drive: assert property (p_drive) else $error("sense pin driven unrouted");
    property p_standby;
        standby == ($past(sense_select) == 3'h7);
    endproperty
    a_standby: assert property (p_standby) else $error("standby mismatch");
    property p_stby_float;
        standby |-> !sense_drive_en;
    endproperty
    a_stby_float: assert property (p_stby_float) else $error("standby drives pin");
    property p_byp_hi;
        $past(sense_select) > 3'h4 |-> !bypass_monitor_bit;
    endproperty
    a_byp_hi: assert property (p_byp_hi) else $error("bypass set with no channel");
    property p_sel_idle;
        $stable(cs_n) [*8] |=> $stable(sense_select);
    endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("select moved off decode");
    property p_err_keep;
        $rose(frame_error_flag) |-> $stable(sense_select);
    endproperty
    a_err_keep: assert property (p_err_keep) else $error("bad frame changed select");

    c_err: cover property ($rose(frame_error_flag));
    c_route: cover property (sense_drive_en);
    c_wake: cover property ($fell(standby));
endmodule
bind diag_serial_slave_port diag_serial_slave_port_checker u_diag_serial_slave_port_checker (
    .clk, .reset_n, .cs_n, .so_oe, .sense_route, .sense_drive_en, .standby,
    .sense_select, .bypass_monitor_bit, .frame_error_flag
);
`default_nettype wire

/* tb/diag_serial_slave_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module diag_serial_slave_port_bench;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        cs_n, sclk, si, so_o, so_oe, pre, limp_pin = 1'b0;
    logic        standby, sense_drive_en, bypass_monitor_bit, frame_error_flag;
    logic [2:0]  sense_select;
    logic [4:0]  on_pins = 5'h0, fault_pins = 5'h0, vds_pins = 5'h0, sense_route;
    logic [7:0]  st;
    logic [15:0] rx;
    int          fail_count = 0;
    int          n_compared = 0;

    assign st = {sense_select, standby, sense_drive_en, frame_error_flag, so_oe,
                 bypass_monitor_bit};
    always #12.5 clk = ~clk;

    diag_serial_master u_diag_serial_master (.cs_n(cs_n), .sclk(sclk), .si(si), .so_o(so_o));
    diag_serial_slave_port u_diag_serial_slave_port (
        .clk(clk), .reset_n(reset_n), .clk_en(1'b1), .sclk(sclk), .cs_n(cs_n), .si(si),
        .so_o(so_o), .so_oe(so_oe), .channel_on_bit(on_pins), .channel_fault_flag(fault_pins),
        .vds_above_thr(vds_pins), .limp_home_indicator(limp_pin), .sense_route(sense_route),
        .sense_drive_en(sense_drive_en), .standby(standby), .sense_select(sense_select),
        .bypass_monitor_bit(bypass_monitor_bit), .frame_error_flag(frame_error_flag)
    );

    task automatic finish_test;
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // pins pass a synchroniser, so give them time to settle
    task automatic pins(input logic [4:0] on, input logic [4:0] flt, input logic limp);
        @(negedge clk);
        on_pins = on;
        fault_pins = flt;
        vds_pins = 5'h0a;
        limp_pin = limp;
        repeat (10) @(negedge clk);
    endtask
    task automatic go(input logic [15:0] tx, input int n);
        u_diag_serial_master.xfer(tx, n, rx, pre);
    endtask

    task automatic t_reset;
        chk(st, 8'hf0);
        chk({3'h0, sense_route}, 8'h00);
    endtask
    task automatic t_codes;
        logic b;
        pins(5'h1f, 5'h00, 1'b0);
        for (int k = 0; k < 8; k++) begin
            go({8'h0, 5'h1e, k[2:0]}, 8);
            b = (k < 5) ? vds_pins[k] : 1'b0;
            chk(st, {k[2:0], k == 7, k < 5, 2'b00, b});
            chk({3'h0, sense_route}, (k < 5) ? 8'h01 << k : 8'h00);
            go(16'h0070, 8);
            go({8'h0, 5'h1e, k[2:0]}, 8);
            chk(rx[7:0] & ((k == 7) ? 8'hf7 : 8'hff), {4'h7, b, k[2:0]});
        end
    endtask
    task automatic t_off;
        pins(5'h1b, 5'h00, 1'b0);
        go(16'h00f2, 8);
        chk({sense_route, sense_drive_en, 2'h0}, 8'h00);
        go(16'h00f3, 8);
        chk({sense_route, sense_drive_en, 2'h0}, 8'h44);
    endtask
    task automatic t_fault;
        pins(5'h1b, 5'h15, 1'b1);
        go(16'h0080, 8);
        chk(st, 8'h69);
        go(16'h0080, 8);
        chk(rx[7:0], 8'h55);
        chk({7'h0, pre}, 8'h00);
    endtask
    task automatic t_bad;
        go(16'h00f5, 7);
        chk(st, 8'h6d);
        go(16'h0000, 0);
        chk(st, 8'h6d);
        go(16'h00f4, 8);
        chk({7'h0, pre}, 8'h01);
        chk({sense_select, frame_error_flag, 4'h0}, 8'h80);
    endtask
    task automatic t_chain;
        go(16'hf1f2, 16);
        chk(rx[15:8], 8'h55);
        chk(rx[7:0], 8'hf1);
        chk({5'h0, sense_select}, 8'h02);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        t_reset;
        t_codes;
        t_off;
        t_fault;
        t_bad;
        t_chain;
        finish_test;
    end
    initial begin
        #400000;
        fail_count++;
        finish_test;
    end
endmodule
`default_nettype wire
